// ### rtl/wwd_pkg.sv
// Purpose : shared constants and state types of the window supervisor
// Assumes : 200 MHz system clock, internal oscillator modelled as a tick
// Notes   : every count is derived from a time in its own unit

// ****************************************************************
// package
// ****************************************************************
package wwd_pkg;

    // ************************************************************
    // clocks
    // ************************************************************
    localparam int CLK_HZ         = 200_000_000;
    localparam int CLK_PERIOD_NS  = 5;
    localparam int OSC_HZ         = 128_000;
    // one oscillator tick per this many system cycles (rounded down)
    localparam int OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;

    // ************************************************************
    // watchdog windows and reset timings
    // ************************************************************
    localparam int CLOSED_WINDOW_TIME_MS = 100;
    localparam int OPEN_WINDOW_TIME_MS   = 100;
    // ticks for one tenth of the nominal window
    localparam int WIN_UNIT_TICKS =
        CLOSED_WINDOW_TIME_MS * (OSC_HZ / 1000) / 10;
    localparam int RESET_PULSE_TIME_MS   = 8;
    localparam int RESET_UNIT_MS         = 4;
    localparam int RST_UNIT_TICKS = RESET_UNIT_MS * (OSC_HZ / 1000);
    localparam int SHUTDOWN_RESET_TIME_MS = 200;
    localparam int SHD_TICKS = SHUTDOWN_RESET_TIME_MS * (OSC_HZ / 1000);
    localparam int DOMINANT_TIMEOUT_MS   = 1000;
    localparam int TXTO_TICKS = DOMINANT_TIMEOUT_MS * (OSC_HZ / 1000);

    // window scale selections, factor in tenths of nominal
    localparam logic [2:0] SCALE_NOM  = 3'h0;
    localparam logic [2:0] SCALE_M40  = 3'h1;
    localparam logic [2:0] SCALE_M20  = 3'h2;
    localparam logic [2:0] SCALE_P20  = 3'h3;
    localparam logic [2:0] SCALE_P60  = 3'h4;
    localparam logic [2:0] SCALE_P100 = 3'h5;

    // reset pulse selections
    localparam logic [1:0] RDLY_8MS  = 2'h0;
    localparam logic [1:0] RDLY_4MS  = 2'h1;
    localparam logic [1:0] RDLY_16MS = 2'h2;
    localparam logic [1:0] RDLY_32MS = 2'h3;

    // ************************************************************
    // pin sequence timing
    // ************************************************************
    localparam int PORT_ENTRY_DELAY_MIN_NS = 2000;
    localparam int PORT_ENTRY_DELAY_MAX_NS = 10000;
    localparam int PORT_ENTRY_MIN_CYCLES =
        (PORT_ENTRY_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PORT_ENTRY_MAX_CYCLES =
        PORT_ENTRY_DELAY_MAX_NS / CLK_PERIOD_NS;
    localparam int LOWPOWER_ENTRY_TIME_TICKS = 5;
    localparam int CLOCK_START_WAIT_TICKS    = 5;

    localparam int TICK_W  = 17;
    localparam int CYC_W   = 12;
    localparam int ETICK_W = 3;

    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [2:0] {
        WD_HOLD   = 3'h0,
        WD_SHDN   = 3'h1,
        WD_CLOSED = 3'h2,
        WD_OPEN   = 3'h3,
        WD_IDLE   = 3'h4
    } wwd_wd_state_t;

    typedef enum logic [1:0] {
        ENT_IDLE = 2'h0,
        ENT_WAIT = 2'h1,
        ENT_PORT = 2'h2
    } wwd_entry_state_t;

endpackage

// ### rtl/wwd_tick_if.sv
// Purpose : carries the internal oscillator tick between modules
// Assumes : tick is a one-cycle pulse in the system clock domain
// Notes   : none

// ****************************************************************
// interface
// ****************************************************************
interface wwd_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input  tick);
endinterface

// ### rtl/wwd_tick.sv
// Purpose : internal oscillator stand-in, one tick pulse per period
// Assumes : system clock runs at the package clock rate
// Notes   : frequency error of the real oscillator is not modelled

// ****************************************************************
// tick divider
// ****************************************************************
module wwd_tick #(
    parameter int DIV = wwd_pkg::OSC_DIV_CYCLES
) (
    input  wire logic clock,
    input  wire logic nrst,
    wwd_tick_if.src   t
);
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    // all durations except the port entry delay, which counts system cycles, derive from this tick
    always_comb begin
        if (cnt_q >= 12'(DIV - 1)) begin
            cnt_d  = 12'h000;
            tick_d = 1'b1;
        end else begin
            cnt_d  = cnt_q + 12'h001;
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign t.tick = tick_q;
endmodule

// ### rtl/wwd_top.sv
// Purpose : window supervisor, reset generator, pin sequence decoder
//           and transmit dominant timeout
// Assumes : all inputs synchronous to clock; service is a one-cycle
//           pulse from the serial port decoder
// Notes   : analog thresholds arrive as the vcc_ok level

// ****************************************************************
// top
// ****************************************************************
// Summary of operation
// - service in closed window forces reset
// - service in open window accepted
// - factory scale of window lengths
// - reset pulse length factory selected
// - temporary shutdown holds reset active
// - same behaviour in normal and standby
// - enable low then transmit low: port entry
// - transmit high five ticks: low power entry
// - flag transmit held dominant too long
// - power-on delay holds reset after power-up
// - no service before open window ends: reset
// - watchdog starts after reset, off on undervoltage
// - timeout releases bus, nominal one second
// - internal tick nominal 128 kHz
module wwd_top #(
    parameter int OSC_DIV        = wwd_pkg::OSC_DIV_CYCLES,
    parameter int WIN_UNIT_TICKS = wwd_pkg::WIN_UNIT_TICKS,
    parameter int RST_UNIT_TICKS = wwd_pkg::RST_UNIT_TICKS,
    parameter int SHD_TICKS      = wwd_pkg::SHD_TICKS,
    parameter int TXTO_TICKS     = wwd_pkg::TXTO_TICKS
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       en,
    input  wire logic       tx,
    input  wire logic       vcc_ok,
    input  wire logic       shutdown_req,
    input  wire logic       service,
    input  wire logic       wd_enable,
    input  wire logic [2:0] win_scale_sel,
    input  wire logic [1:0] rst_delay_sel,
    output logic            reset_n,
    output logic            bus_txd,
    output logic            tx_timeout,
    output logic            port_entry,
    output logic            lowpower_entry,
    output logic            port_active,
    output logic            port_clock_ready
);
    localparam int TW = wwd_pkg::TICK_W;
    localparam int CW = wwd_pkg::CYC_W;
    localparam int EW = wwd_pkg::ETICK_W;

    // ************************************************************
    // oscillator tick
    // ************************************************************
    wwd_tick_if tk_if ();

    wwd_tick #(
        .DIV (OSC_DIV)
    ) u_tick (
        .clock (clock),
        .nrst  (nrst),
        .t     (tk_if.src)
    );

    logic tick;
    assign tick = tk_if.tick;

    // ************************************************************
    // factory selected lengths
    // ************************************************************
    logic [TW-1:0] win_len;
    logic [TW-1:0] rst_len;

    always_comb begin
        unique case (win_scale_sel)
            wwd_pkg::SCALE_M40:  win_len = TW'(WIN_UNIT_TICKS * 6);
            wwd_pkg::SCALE_M20:  win_len = TW'(WIN_UNIT_TICKS * 8);
            wwd_pkg::SCALE_P20:  win_len = TW'(WIN_UNIT_TICKS * 12);
            wwd_pkg::SCALE_P60:  win_len = TW'(WIN_UNIT_TICKS * 16);
            wwd_pkg::SCALE_P100: win_len = TW'(WIN_UNIT_TICKS * 20);
            default:             win_len = TW'(WIN_UNIT_TICKS * 10);
        endcase
    end

    always_comb begin
        unique case (rst_delay_sel)
            wwd_pkg::RDLY_4MS:  rst_len = TW'(RST_UNIT_TICKS);
            wwd_pkg::RDLY_16MS: rst_len = TW'(RST_UNIT_TICKS * 4);
            wwd_pkg::RDLY_32MS: rst_len = TW'(RST_UNIT_TICKS * 8);
            default:            rst_len = TW'(RST_UNIT_TICKS * 2);
        endcase
    end

    // ************************************************************
    // watchdog and reset sequencer
    // ************************************************************
    wwd_pkg::wwd_wd_state_t wd_state_q;
    wwd_pkg::wwd_wd_state_t wd_state_d;
    logic [TW-1:0]          wd_cnt_q;
    logic [TW-1:0]          wd_cnt_d;
    logic                   rst_n_q;
    logic                   rst_n_d;
    logic                   wd_done;
    logic [TW-1:0]          wd_len;
    logic                   wd_run;

    // no mode input, standby and normal share this logic
    always_comb begin
        unique case (wd_state_q)
            wwd_pkg::WD_HOLD:   wd_len = rst_len;
            wwd_pkg::WD_SHDN:   wd_len = TW'(SHD_TICKS);
            wwd_pkg::WD_CLOSED: wd_len = win_len;
            wwd_pkg::WD_OPEN:   wd_len = win_len;
            default:            wd_len = win_len;
        endcase
    end

    assign wd_run  = (wd_state_q != wwd_pkg::WD_IDLE);
    assign wd_done = tick && (wd_cnt_q >= wd_len - TW'(1));

    always_comb begin
        wd_state_d = wd_state_q;
        wd_cnt_d   = wd_cnt_q;
        if (wd_run && tick) begin
            wd_cnt_d = wd_cnt_q + TW'(1);
        end
        unique case (wd_state_q)
            wwd_pkg::WD_HOLD, wwd_pkg::WD_SHDN: begin
                if (wd_done) begin
                    wd_state_d = wd_enable ? wwd_pkg::WD_CLOSED
                                           : wwd_pkg::WD_IDLE;
                    wd_cnt_d   = '0;
                end
            end
            wwd_pkg::WD_CLOSED: begin
                if (service) begin
                    wd_state_d = wwd_pkg::WD_HOLD;
                    wd_cnt_d   = '0;
                end else if (wd_done) begin
                    wd_state_d = wwd_pkg::WD_OPEN;
                    wd_cnt_d   = '0;
                end
            end
            wwd_pkg::WD_OPEN: begin
                if (service) begin
                    wd_state_d = wwd_pkg::WD_CLOSED;
                    wd_cnt_d   = '0;
                end else if (wd_done) begin
                    wd_state_d = wwd_pkg::WD_HOLD;
                    wd_cnt_d   = '0;
                end
            end
            wwd_pkg::WD_IDLE: begin
                if (wd_enable) begin
                    wd_state_d = wwd_pkg::WD_CLOSED;
                    wd_cnt_d   = '0;
                end
            end
            default: begin
                wd_state_d = wwd_pkg::WD_HOLD;
                wd_cnt_d   = '0;
            end
        endcase
        if (shutdown_req && wd_state_q != wwd_pkg::WD_SHDN) begin
            wd_state_d = wwd_pkg::WD_SHDN;
            wd_cnt_d   = '0;
        end
        if (!vcc_ok) begin
            wd_state_d = wwd_pkg::WD_HOLD;
            wd_cnt_d   = '0;
        end
        rst_n_d = (wd_state_d == wwd_pkg::WD_CLOSED) ||
                  (wd_state_d == wwd_pkg::WD_OPEN)   ||
                  (wd_state_d == wwd_pkg::WD_IDLE);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wd_state_q <= wwd_pkg::WD_HOLD;
            wd_cnt_q   <= '0;
            rst_n_q    <= 1'b0;
        end else begin
            wd_state_q <= wd_state_d;
            wd_cnt_q   <= wd_cnt_d;
            rst_n_q    <= rst_n_d;
        end
    end

    assign reset_n = rst_n_q;

    // ************************************************************
    // enable / transmit entry decoder
    // ************************************************************
    wwd_pkg::wwd_entry_state_t ent_state_q;
    wwd_pkg::wwd_entry_state_t ent_state_d;
    logic [CW-1:0]             ent_cyc_q;
    logic [CW-1:0]             ent_cyc_d;
    logic [EW-1:0]             ent_tk_q;
    logic [EW-1:0]             ent_tk_d;
    logic                      en_q;
    logic                      port_entry_q;
    logic                      port_entry_d;
    logic                      lp_entry_q;
    logic                      lp_entry_d;
    logic                      pclk_rdy_q;
    logic                      pclk_rdy_d;
    logic                      en_fall;

    assign en_fall = en_q && !en;

    always_comb begin
        ent_state_d  = ent_state_q;
        ent_cyc_d    = ent_cyc_q;
        ent_tk_d     = ent_tk_q;
        port_entry_d = 1'b0;
        lp_entry_d   = 1'b0;
        // saturating counters, only compared against small limits
        if (ent_cyc_q != {CW{1'b1}}) begin
            ent_cyc_d = ent_cyc_q + CW'(1);
        end
        if (tick && ent_tk_q != {EW{1'b1}}) begin
            ent_tk_d = ent_tk_q + EW'(1);
        end
        unique case (ent_state_q)
            wwd_pkg::ENT_IDLE: begin
                if (en_fall) begin
                    ent_state_d = wwd_pkg::ENT_WAIT;
                    ent_cyc_d   = CW'(1);
                    ent_tk_d    = '0;
                end
            end
            wwd_pkg::ENT_WAIT: begin
                if (en) begin
                    ent_state_d = wwd_pkg::ENT_IDLE;
                end else if (!tx) begin
                    if (ent_cyc_q >= CW'(wwd_pkg::PORT_ENTRY_MIN_CYCLES) &&
                        ent_cyc_q <= CW'(wwd_pkg::PORT_ENTRY_MAX_CYCLES))
                    begin
                        ent_state_d  = wwd_pkg::ENT_PORT;
                        port_entry_d = 1'b1;
                    end else begin
                        ent_state_d = wwd_pkg::ENT_IDLE;
                    end
                end else if (ent_tk_q >=
                             EW'(wwd_pkg::LOWPOWER_ENTRY_TIME_TICKS)) begin
                    ent_state_d = wwd_pkg::ENT_IDLE;
                    lp_entry_d  = 1'b1;
                end
            end
            wwd_pkg::ENT_PORT: begin
                if (en) begin
                    ent_state_d = wwd_pkg::ENT_IDLE;
                end
            end
            default: begin
                ent_state_d = wwd_pkg::ENT_IDLE;
            end
        endcase
        pclk_rdy_d = (ent_state_d == wwd_pkg::ENT_PORT) &&
                     (ent_tk_d >= EW'(wwd_pkg::CLOCK_START_WAIT_TICKS));
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ent_state_q  <= wwd_pkg::ENT_IDLE;
            ent_cyc_q    <= '0;
            ent_tk_q     <= '0;
            en_q         <= 1'b1;
            port_entry_q <= 1'b0;
            lp_entry_q   <= 1'b0;
            pclk_rdy_q   <= 1'b0;
        end else begin
            ent_state_q  <= ent_state_d;
            ent_cyc_q    <= ent_cyc_d;
            ent_tk_q     <= ent_tk_d;
            en_q         <= en;
            port_entry_q <= port_entry_d;
            lp_entry_q   <= lp_entry_d;
            pclk_rdy_q   <= pclk_rdy_d;
        end
    end

    assign port_entry       = port_entry_q;
    assign lowpower_entry   = lp_entry_q;
    assign port_active      = (ent_state_q == wwd_pkg::ENT_PORT);
    assign port_clock_ready = pclk_rdy_q;

    // ************************************************************
    // transmit dominant timeout
    // ************************************************************
    logic [TW-1:0] dom_cnt_q;
    logic [TW-1:0] dom_cnt_d;
    logic          txto_q;
    logic          txto_d;
    logic          txd_q;
    logic          txd_d;

    always_comb begin
        dom_cnt_d = dom_cnt_q;
        txto_d    = txto_q;
        if (tx || !vcc_ok) begin
            dom_cnt_d = '0;
            txto_d    = 1'b0;
        end else if (!txto_q && tick) begin
            dom_cnt_d = dom_cnt_q + TW'(1);
            if (dom_cnt_q >= TW'(TXTO_TICKS - 1)) begin
                txto_d = 1'b1;
            end
        end
        txd_d = tx || txto_d;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dom_cnt_q <= '0;
            txto_q    <= 1'b0;
            txd_q     <= 1'b1;
        end else begin
            dom_cnt_q <= dom_cnt_d;
            txto_q    <= txto_d;
            txd_q     <= txd_d;
        end
    end

    assign tx_timeout = txto_q;
    assign bus_txd    = txd_q;
endmodule

// ### verification/wwd_top_asserts.sv
// Purpose : port-level checks of the window supervisor
// Assumes : bound into wwd_top, counts handed on as parameters
// Notes   : helper counters saturate, so long idles stay harmless
// ********
// checker
// ********
module wwd_top_asserts #(
    parameter int OSC_DIV    = 4,
    parameter int TXTO_TICKS = 20
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic en,
    input wire logic tx,
    input wire logic vcc_ok,
    input wire logic shutdown_req,
    input wire logic reset_n,
    input wire logic bus_txd,
    input wire logic tx_timeout,
    input wire logic port_entry,
    input wire logic lowpower_entry,
    input wire logic port_active,
    input wire logic port_clock_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] en_cnt_q;
    logic [15:0] tx_cnt_q;
    // cycles since enable fell and since transmit went dominant
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            en_cnt_q <= 16'h0000;
            tx_cnt_q <= 16'h0000;
        end else begin
            en_cnt_q <= en ? 16'h0000 : en_cnt_q + {15'h0000, ~&en_cnt_q};
            tx_cnt_q <= tx ? 16'h0000 : tx_cnt_q + {15'h0000, ~&tx_cnt_q};
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    por_hold_a: assert property ($rose(nrst) |-> !reset_n)
        else $error("reset output released at power-up");
    uv_hold_a: assert property (!vcc_ok [*2] |-> !reset_n)
        else $error("reset output high under undervoltage");
    shd_reset_a: assert property ($rose(shutdown_req) |->
        ##[1:2] !reset_n)
        else $error("shutdown did not pull reset low");
    txd_path_a: assert property (bus_txd == ($past(tx) | tx_timeout))
        else $error("bus transmit level wrong");
    to_clear_a: assert property (tx_timeout && tx |=> !tx_timeout)
        else $error("timeout flag kept after recessive");
    to_span_a: assert property ($rose(tx_timeout) |->
        int'(tx_cnt_q) > (TXTO_TICKS - 1) * OSC_DIV
        && int'(tx_cnt_q) <= TXTO_TICKS * OSC_DIV + 1)
        else $error("timeout after wrong dominant span");
    port_req_a: assert property (port_entry |-> port_active
        && !$past(tx) && int'(en_cnt_q) >= 401
        && int'(en_cnt_q) <= 2001 ##1 !port_entry)
        else $error("port entry outside its delay span");
    lp_req_a: assert property (lowpower_entry |-> $past(tx)
        && int'(en_cnt_q) > 4 * OSC_DIV
        && int'(en_cnt_q) <= 5 * OSC_DIV + 2 ##1 !lowpower_entry)
        else $error("low power entry at wrong time");
    en_abort_a: assert property (en |=> !port_active)
        else $error("port mode kept with enable high");
    clk_ready_a: assert property (port_clock_ready && !en |->
        int'(en_cnt_q) > 4 * OSC_DIV)
        else $error("port clock allowed too early");
    cover property (port_entry);
    cover property (lowpower_entry);
    cover property ($rose(tx_timeout));
    cover property ($rose(reset_n));
endmodule

bind wwd_top wwd_top_asserts #(
    .OSC_DIV(OSC_DIV), .TXTO_TICKS(TXTO_TICKS)
) u_wwd_top_asserts (
    .clock(clock), .nrst(nrst), .en(en), .tx(tx), .vcc_ok(vcc_ok),
    .shutdown_req(shutdown_req), .reset_n(reset_n), .bus_txd(bus_txd),
    .tx_timeout(tx_timeout), .port_entry(port_entry),
    .lowpower_entry(lowpower_entry), .port_active(port_active),
    .port_clock_ready(port_clock_ready)
);

// ### verification/wwd_host.sv
// Purpose : host controller model on the enable and transmit pins
// Assumes : every pin change lands on a falling clock edge
// Notes   : pins are always driven, so no released level exists
// ********
// host model
// ********
module wwd_host (
    input  wire logic clock,
    input  wire logic port_clock_ready,
    output logic      en,
    output logic      tx,
    output logic      service
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        en = 1'h1;
        tx = 1'h1;
        service = 1'h0;
    end
    task automatic trig();
        @(negedge clock) service = 1'h1;
        @(negedge clock) service = 1'h0;
    endtask
    // enable low, transmit low gap cycles later
    task automatic entry(input int gap);
        @(negedge clock) en = 1'h0;
        repeat (gap) @(negedge clock);
        tx = 1'h0;
    endtask
    // first port clock only once the wait is over
    task automatic clock_out();
        int n;
        n = 0;
        while (port_clock_ready !== 1'h1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        tx = 1'h1;
        @(negedge clock) tx = 1'h0;
    endtask
    // enable low with transmit left high
    task automatic lp_start();
        @(negedge clock) en = 1'h0;
    endtask
    task automatic release_pins();
        @(negedge clock) en = 1'h1;
        tx = 1'h1;
    endtask
    task automatic tx_level(input logic v);
        @(negedge clock) tx = v;
    endtask
endmodule

// ### verification/wwd_top_tb_top.sv
// Purpose : self-checking bench of the window supervisor
// Assumes : oscillator tick shortened to one per 100 cycles
// Notes   : reset lengths allow one partial tick at entry
// ********
// bench
// ********
module wwd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 100;
    logic       clock = 1'h0;
    logic       nrst;
    logic       vcc_ok;
    logic       shutdown_req;
    logic       en;
    logic       tx;
    logic       service;
    logic       wd_enable;
    logic [2:0] win_scale_sel;
    logic [1:0] rst_delay_sel;
    logic       reset_n;
    logic       bus_txd;
    logic       tx_timeout;
    logic       port_entry;
    logic       lowpower_entry;
    logic       port_active;
    logic       port_clock_ready;
    int         n_errors = 0;
    int         n_compared = 0;

    always #2.5 clock = ~clock;

    wwd_top #(.OSC_DIV(D), .WIN_UNIT_TICKS(1), .RST_UNIT_TICKS(1),
        .SHD_TICKS(4), .TXTO_TICKS(4)) u_wwd_top (
        .clock(clock), .nrst(nrst), .en(en), .tx(tx), .vcc_ok(vcc_ok),
        .shutdown_req(shutdown_req), .service(service),
        .wd_enable(wd_enable), .win_scale_sel(win_scale_sel),
        .rst_delay_sel(rst_delay_sel), .reset_n(reset_n),
        .bus_txd(bus_txd), .tx_timeout(tx_timeout),
        .port_entry(port_entry), .lowpower_entry(lowpower_entry),
        .port_active(port_active), .port_clock_ready(port_clock_ready));
    wwd_host u_wwd_host (.clock(clock), .port_clock_ready(port_clock_ready),
        .en(en), .tx(tx), .service(service));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error %s expected %0h seen %0h", what, exp, seen);
            n_errors++;
        end
    endtask
    function automatic logic [31:0] rng(input int n, lo, hi);
        return {31'h0, (n >= lo) && (n <= hi)};
    endfunction
    task automatic wait_rst(input logic v, output int n);
        n = 0;
        while (reset_n !== v && n < 20000) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic hold(input int c, output int lows);
        lows = 0;
        repeat (c) begin
            @(negedge clock);
            lows += (reset_n !== 1'h1);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_service();
        int n;
        int lows;
        hold(1498, lows);
        u_wwd_host.trig();
        hold(1500, n);
        lows += n;
        u_wwd_host.trig();
        hold(300, n);
        check("open_service", lows + n, 0);
        rst_delay_sel = wwd_pkg::RDLY_32MS;
        u_wwd_host.trig();
        repeat (2) @(negedge clock);
        check("early_service", reset_n, 0);
        wait_rst(1'h1, n);
        check("reset_32", rng(n, 7 * D - 4, 8 * D + 3), 1);
    endtask
    task automatic t_scales();
        logic [2:0] sc [6] = '{wwd_pkg::SCALE_NOM, wwd_pkg::SCALE_M40,
            wwd_pkg::SCALE_M20, wwd_pkg::SCALE_P20, wwd_pkg::SCALE_P60,
            wwd_pkg::SCALE_P100};
        logic [1:0] rs [6] = '{wwd_pkg::RDLY_16MS, wwd_pkg::RDLY_4MS,
            wwd_pkg::RDLY_8MS, wwd_pkg::RDLY_32MS, wwd_pkg::RDLY_16MS,
            wwd_pkg::RDLY_4MS};
        int f [6] = '{10, 6, 8, 12, 16, 20};
        int rl [6] = '{4, 1, 2, 8, 4, 1};
        int n;
        for (int i = 0; i < 6; i++) begin
            rst_delay_sel = rs[i];
            wait_rst(1'h0, n);
            win_scale_sel = sc[i];
            wait_rst(1'h1, n);
            check("reset_len", rng(n, (rl[i] - 1) * D - 2,
                rl[i] * D + 3), 1);
            wait_rst(1'h0, n);
            check("missed_window", rng(n, (2 * f[i] - 1) * D,
                2 * f[i] * D + 3), 1);
        end
    endtask
    task automatic t_supply();
        int n;
        wait_rst(1'h1, n);
        rst_delay_sel = wwd_pkg::RDLY_8MS;
        shutdown_req = 1'h1;
        @(negedge clock) shutdown_req = 1'h0;
        @(negedge clock);
        check("shutdown_low", reset_n, 0);
        wait_rst(1'h1, n);
        check("shutdown_len", rng(n, 3 * D - 4, 6 * D + 3), 1);
        // watchdog disabled: after this reset no windows may run
        wd_enable = 1'h0;
        vcc_ok = 1'h0;
        hold(2, n);
        hold(400, n);
        check("uv_hold", n, 400);
        vcc_ok = 1'h1;
        wait_rst(1'h1, n);
        check("uv_release", rng(n, D - 2, 2 * D + 3), 1);
        hold(4100, n);
        check("wd_off", n, 0);
        wd_enable = 1'h1;
    endtask
    task automatic t_entry();
        int n;
        u_wwd_host.entry(399);
        repeat (2) @(negedge clock);
        check("entry_early", {port_entry, port_active}, 0);
        u_wwd_host.release_pins();
        repeat (2) @(negedge clock);
        u_wwd_host.entry(400);
        @(negedge clock);
        check("entry_ok", {port_entry, port_active}, 3);
        u_wwd_host.clock_out();
        check("clock_ready", port_clock_ready, 1);
        u_wwd_host.release_pins();
        @(negedge clock);
        check("port_off", port_active, 0);
        u_wwd_host.lp_start();
        n = 0;
        while (lowpower_entry !== 1'h1 && n < 6 * D) begin
            @(negedge clock);
            n++;
        end
        check("lowpower_time", rng(n, 4 * D, 5 * D + 2), 1);
        u_wwd_host.release_pins();
    endtask
    task automatic t_timeout();
        int n;
        u_wwd_host.tx_level(1'h0);
        @(negedge clock);
        check("txd_dominant", bus_txd, 0);
        n = 1;
        while (tx_timeout !== 1'h1 && n < 6 * D) begin
            @(negedge clock);
            n++;
        end
        check("timeout_span", rng(n, 3 * D + 1, 4 * D + 2), 1);
        check("txd_released", bus_txd, 1);
        u_wwd_host.tx_level(1'h1);
        @(negedge clock);
        check("timeout_clear", tx_timeout, 0);
    endtask

    initial begin
        int n;
        nrst = 1'h0;
        vcc_ok = 1'h1;
        shutdown_req = 1'h0;
        wd_enable = 1'h1;
        win_scale_sel = wwd_pkg::SCALE_NOM;
        rst_delay_sel = wwd_pkg::RDLY_8MS;
        repeat (12) @(negedge clock);
        nrst = 1'h1;
        wait_rst(1'h1, n);
        check("power_on", rng(n, D, 2 * D + 3), 1);
        t_service();
        t_scales();
        t_supply();
        t_entry();
        t_timeout();
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clock);
        n_errors++;
        conclude();
    end
endmodule
